/* File: logic/gciv_pkg.sv */
// Purpose: Shared constants and types of the general control and irq vector block
// Assumes: 8-bit registers on a plain strobe port, one 50 MHz clock
// Notes: Event, mask and pin status registers sit in spare space of the window
package gciv_pkg;
  // ==========================================================
  // Register map
  localparam logic [31:0] GEN_CTRL_ADDR = 32'hfff42002;
  localparam logic [31:0] VEC_BASE_ADDR = 32'hfff42003;
  localparam logic [31:0] EVT_STAT_ADDR = 32'hfff420f0;
  localparam logic [31:0] EVT_MASK_ADDR = 32'hfff420f1;
  localparam logic [31:0] PIN_STAT_ADDR = 32'hfff420f2;
  // ==========================================================
  // Field layout and reset values
  localparam int GC_BOOT_BIT = 7;
  localparam int GC_CPU_BIT = 2;
  localparam int GC_MASTER_IRQ_ENABLE_BIT = 1;
  localparam int GC_FAST_BIT = 0;
  localparam int VB_LO = 4;
  localparam logic [7:0] VEC_RESET = 8'h0f;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] PINS_IDLE_N = 3'h7;
  // ==========================================================
  // Interrupt sources
  localparam int NUM_SRC = 14;
  localparam logic [3:0] SRC_SER_MODEM = 4'hb;
  localparam logic [3:0] SRC_SER_RX = 4'hc;
  localparam logic [3:0] SRC_SER_TX = 4'hd;
  localparam logic [31:0] DROM0_TOP = 32'h0001ffff;
  // ==========================================================
  // Events of the sticky status register
  localparam int EVT_W = 3;
  localparam int EVT_BOOT = 0;
  localparam int EVT_PASS = 1;
  localparam int EVT_FETCH = 2;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BOOT_TIMEOUT_NS = 2000;
  localparam int BOOT_TIMEOUT_CYC = (BOOT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  // ==========================================================
  // Types
  typedef logic [NUM_SRC-1:0][2:0] gciv_lvls_t;
  typedef enum logic [1:0] {ACK_IDLE = 2'b00, ACK_FETCH = 2'b01} gciv_ack_e;
  typedef enum logic [1:0] {
    BOOT_ARMED = 2'b00,
    BOOT_TIMING = 2'b01,
    BOOT_DONE = 2'b11
  } gciv_boot_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gciv_regreq_s;
  typedef struct packed {
    logic req;
    logic [2:0] level;
  } gciv_iack_s;
  typedef struct packed {
    logic done;
    logic [7:0] vector;
  } gciv_iack_ans_s;
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } gciv_servec_s;
  typedef struct packed {
    logic start;
    logic [31:0] addr;
    logic responded;
  } gciv_mem_s;
endpackage

/* File: logic/gciv_prio_enc.sv */
// Purpose: Picks the highest-coded active request
// Assumes: Request bit index equals the source code
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
module gciv_prio_enc #(
  parameter int N = 14
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [3:0] o_code
);
  // ==========================================================
  // Later index overrides earlier, so higher code wins
  always_comb begin
    o_any = 1'b0;
    o_code = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_code = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/gciv_sync3.sv */
// Purpose: Three-stage input synchroniser for pins
// Assumes: Input is asynchronous to i_clk_sys
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module gciv_sync3 #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gciv_sync_s;
  gciv_sync_s st_q;
  gciv_sync_s st_d;
  // ==========================================================
  // Shift and agree; the first stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.q = st_q.s3;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= {INIT, INIT, INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end
  assign o_sync = st_q.q;
endmodule
`default_nettype wire

/* File: logic/gciv_top.sv */
// Purpose: General control and interrupt vector logic of a local-bus peripheral controller
// Assumes: Synchronous active-high reset covers power-up and local reset
// Notes: Acknowledge answers one cycle after the request unless a serial fetch is needed
// Behaviour
// (R1) Master enable gates pins and interrupt output
// (R2) Enable low: pass every acknowledge onward
// (R3) Reset clears master enable
// (R4) Family select drives level pins, else inputs
// (R5) Boot alias maps ROM at zero
// (R6) Reset clears alias; first-access timeout sets it
// (R7) Software picks fast RAM timing by speed
// (R8) Vector is base nibble plus source code
// (R9) Vector 0F until base register written
// (R10) Base reads 0F, then nibble with zeros
// (R11) Codes 0-7: printer, SCSI, LAN sources
// (R12) Codes 8-D: timers, GPIO, serial sources
// (R13) Higher source code wins
// (R14) Serial without autovector: fetch external vector
// (R15) Software advised base 50, serial 5C
// (R16) Low base bits, unused bits ignored
`timescale 1ns/1ns
`default_nettype none
module gciv_top
  import gciv_pkg::*;
#(
  parameter int BOOT_TIMEOUT = gciv_pkg::BOOT_TIMEOUT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire gciv_pkg::gciv_regreq_s i_reg,
  output logic [7:0] o_reg_rdata,
  input wire logic [gciv_pkg::NUM_SRC-1:0] i_src_req,
  input wire gciv_pkg::gciv_lvls_t i_src_level,
  input wire logic [2:0] i_serial_autovector_enable,
  input wire gciv_pkg::gciv_iack_s i_iack,
  output gciv_pkg::gciv_iack_ans_s o_iack,
  output logic o_ack_passthrough_out_n,
  output logic o_ser_vec_fetch,
  input wire gciv_pkg::gciv_servec_s i_ser_vec,
  input wire logic [2:0] i_encoded_irq_level_pins_in_n,
  output logic [2:0] o_encoded_irq_level_pins_out_n,
  output logic o_encoded_irq_level_pins_oe,
  output logic o_chip_irq,
  input wire gciv_pkg::gciv_mem_s i_mem,
  output logic o_download_rom_sel,
  output logic o_download_rom_claim,
  output logic o_battery_ram_fast_timing,
  output logic o_irq
);
  import gciv_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic master_irq_enable;
    logic cpu_sel;
    logic boot0;
    logic fast;
    logic [3:0] vb_nib;
    logic vb_written;
    gciv_ack_e ack_st;
    gciv_boot_e boot_st;
    logic [CNT_W-1:0] boot_cnt;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic [7:0] rdata;
    logic [2:0] level;
    logic chip_irq;
    logic evt_irq;
    logic iack_done;
    logic [7:0] iack_vec;
    logic pass;
    logic fetch;
    logic claim;
  } gciv_top_s;

  gciv_top_s st_q;
  gciv_top_s st_d;

  localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_TIMEOUT - 1);

  // ==========================================================
  // Helpers
  // Highest level among active sources
  function automatic logic [2:0] max_level(
    input logic [NUM_SRC-1:0] req,
    input gciv_lvls_t lvls
  );
    logic [2:0] m;
    m = LVL_NONE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && (lvls[i] > m)) begin
        m = lvls[i];
      end
    end
    return m;
  endfunction

  // Vector from base nibble and code, or the post-reset value
  function automatic logic [7:0] make_vec(
    input logic written,
    input logic [3:0] nib,
    input logic [3:0] code
  );
    return written ? {nib, code} : VEC_RESET;
  endfunction

  // Readback of the base register
  function automatic logic [7:0] vb_read(
    input logic written,
    input logic [3:0] nib
  );
    return written ? {nib, NIB_ZERO} : VEC_RESET;
  endfunction

  // ==========================================================
  // Source selection for the acknowledged level
  logic [NUM_SRC-1:0] elig;
  logic win_any;
  logic [3:0] win_code;
  logic [2:0] pins_sync_n;
  logic win_serial;
  logic win_serial_autovector_enable;
  logic wr_gc;
  logic wr_vb;
  logic wr_es;
  logic wr_em;
  logic [EVT_W-1:0] evt_set;

  // Only sources at the level being acknowledged compete
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      elig[i] = i_src_req[i] && (i_src_level[i] == i_iack.level);
    end
  end

  gciv_prio_enc #(
    .N(NUM_SRC)
  ) i_gciv_prio_enc (
    .i_req(elig),
    .o_any(win_any),
    .o_code(win_code)
  );

  gciv_sync3 #(
    .W(3),
    .INIT(PINS_IDLE_N)
  ) i_gciv_sync3 (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_encoded_irq_level_pins_in_n),
    .o_sync(pins_sync_n)
  );

  // Serial codes follow their own autovector bit
  always_comb begin
    win_serial = (win_code >= SRC_SER_MODEM);
    case (win_code)
      SRC_SER_MODEM: win_serial_autovector_enable = i_serial_autovector_enable[0];
      SRC_SER_RX: win_serial_autovector_enable = i_serial_autovector_enable[1];
      SRC_SER_TX: win_serial_autovector_enable = i_serial_autovector_enable[2];
      default: win_serial_autovector_enable = 1'b1;
    endcase
  end

  // Address decode of register writes
  assign wr_gc = i_reg.wr && (i_reg.addr == GEN_CTRL_ADDR);
  assign wr_vb = i_reg.wr && (i_reg.addr == VEC_BASE_ADDR);
  assign wr_es = i_reg.wr && (i_reg.addr == EVT_STAT_ADDR);
  assign wr_em = i_reg.wr && (i_reg.addr == EVT_MASK_ADDR);

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    evt_set = '0;
    st_d.iack_done = 1'b0;
    st_d.pass = 1'b0;
    st_d.claim = 1'b0;
    st_d.rdata = BYTE_ZERO;

    // Control bits; unused bits are simply dropped (see R16)
    if (wr_gc) begin
      st_d.master_irq_enable = i_reg.wdata[GC_MASTER_IRQ_ENABLE_BIT];
      st_d.cpu_sel = i_reg.wdata[GC_CPU_BIT];
      st_d.boot0 = i_reg.wdata[GC_BOOT_BIT];
      st_d.fast = i_reg.wdata[GC_FAST_BIT];
    end
    // Only the high nibble is kept (see R16)
    if (wr_vb) begin
      st_d.vb_nib = i_reg.wdata[7:VB_LO];
      st_d.vb_written = 1'b1;
    end
    if (wr_em) begin
      st_d.evt_mask = i_reg.wdata[EVT_W-1:0];
    end

    // Boot alias: armed by reset, first access is timed (see R6)
    case (st_q.boot_st)
      BOOT_ARMED: begin
        if (i_mem.start) begin
          st_d.boot_st = i_mem.responded ? BOOT_DONE : BOOT_TIMING;
          st_d.boot_cnt = '0;
        end
      end
      BOOT_TIMING: begin
        if (i_mem.responded) begin
          st_d.boot_st = BOOT_DONE;
        end else if (st_q.boot_cnt == BOOT_LAST) begin
          st_d.boot0 = 1'b1; // see R6
          st_d.claim = 1'b1;
          evt_set[EVT_BOOT] = 1'b1;
          st_d.boot_st = BOOT_DONE;
        end else begin
          st_d.boot_cnt = st_q.boot_cnt + 1'b1;
        end
      end
      BOOT_DONE: begin
        st_d.boot_st = BOOT_DONE;
      end
      default: begin
        st_d.boot_st = BOOT_DONE;
      end
    endcase

    // Acknowledge handling
    case (st_q.ack_st)
      ACK_IDLE: begin
        if (i_iack.req) begin
          if (!st_q.master_irq_enable || !win_any) begin
            // Not ours or gated off: hand onward (see R2)
            st_d.pass = 1'b1;
            evt_set[EVT_PASS] = 1'b1;
          end else if (win_serial && !win_serial_autovector_enable) begin
            // Vector comes from the serial controller (see R14)
            st_d.fetch = 1'b1;
            st_d.ack_st = ACK_FETCH;
          end else begin
            // Base nibble with source code (see R8, R11, R12, R13, R9)
            st_d.iack_done = 1'b1;
            st_d.iack_vec = make_vec(st_q.vb_written, st_q.vb_nib, win_code);
          end
        end
      end
      ACK_FETCH: begin
        // Further requests wait; the fetch is not interruptible
        if (i_ser_vec.valid) begin
          st_d.fetch = 1'b0;
          st_d.iack_done = 1'b1;
          st_d.iack_vec = i_ser_vec.vector; // see R14
          evt_set[EVT_FETCH] = 1'b1;
          st_d.ack_st = ACK_IDLE;
        end
      end
      default: begin
        st_d.fetch = 1'b0;
        st_d.ack_st = ACK_IDLE;
      end
    endcase

    // Sticky events: a set in the clearing cycle survives
    st_d.evt_stat = (st_q.evt_stat & ~(wr_es ? i_reg.wdata[EVT_W-1:0] : '0)) | evt_set;

    // Readback, valid only in the cycle after the strobe
    if (i_reg.rd) begin
      case (i_reg.addr)
        GEN_CTRL_ADDR: begin
          st_d.rdata[GC_BOOT_BIT] = st_q.boot0;
          st_d.rdata[GC_CPU_BIT] = st_q.cpu_sel;
          st_d.rdata[GC_MASTER_IRQ_ENABLE_BIT] = st_q.master_irq_enable;
          st_d.rdata[GC_FAST_BIT] = st_q.fast;
        end
        VEC_BASE_ADDR: st_d.rdata = vb_read(st_q.vb_written, st_q.vb_nib); // see R10
        EVT_STAT_ADDR: st_d.rdata[EVT_W-1:0] = st_q.evt_stat;
        EVT_MASK_ADDR: st_d.rdata[EVT_W-1:0] = st_q.evt_mask;
        PIN_STAT_ADDR: st_d.rdata[2:0] = ~pins_sync_n;
        default: st_d.rdata = BYTE_ZERO;
      endcase
    end

    // Outgoing request level and interrupt lines, all gated (see R1)
    st_d.level = st_q.master_irq_enable ? max_level(i_src_req, i_src_level) : LVL_NONE;
    st_d.chip_irq = st_q.master_irq_enable && (|i_src_req);
    st_d.evt_irq = st_q.master_irq_enable && (|(st_q.evt_stat & st_q.evt_mask));
  end

  // ==========================================================
  // Registers; reset blocks interrupts and clears the alias
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= '0; // see R3
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // Pins driven only for the processor family setting (see R4)
  assign o_encoded_irq_level_pins_oe = st_q.cpu_sel;
  assign o_encoded_irq_level_pins_out_n = ~st_q.level;
  assign o_chip_irq = st_q.chip_irq;
  assign o_irq = st_q.evt_irq;
  assign o_reg_rdata = st_q.rdata;
  assign o_iack.done = st_q.iack_done;
  assign o_iack.vector = st_q.iack_vec;
  assign o_ack_passthrough_out_n = ~st_q.pass; // Stored high so reset leaves it idle
  assign o_ser_vec_fetch = st_q.fetch;
  assign o_download_rom_claim = st_q.claim;
  assign o_battery_ram_fast_timing = st_q.fast;
  // Decode of the alias window; normal range is decoded outside (see R5)
  assign o_download_rom_sel = st_q.boot0 && (i_mem.addr <= DROM0_TOP);

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  AST_MASTER_IRQ_ENABLE_GATES: assert property ( // see R1
    !st_q.master_irq_enable |=> (o_encoded_irq_level_pins_out_n == PINS_IDLE_N) && !o_chip_irq && !o_irq
  ) else $error("interrupt escaped while master enable low");
  AST_PASS_WHEN_OFF: assert property ( // see R2
    (i_iack.req && !st_q.master_irq_enable && (st_q.ack_st == ACK_IDLE))
      |=> !o_ack_passthrough_out_n && !o_iack.done
      ##1 (o_ack_passthrough_out_n || $past(i_iack.req))
  ) else $error("acknowledge not passed on");
  AST_RESET_STATE: assert property ( // see R3
    $past(i_sys_rst) |-> !st_q.master_irq_enable && !st_q.boot0 && !o_encoded_irq_level_pins_oe
  ) else $error("bad state after reset");
  AST_OE_FROM_WRITE: assert property ( // see R4
    wr_gc |=> o_encoded_irq_level_pins_oe == $past(i_reg.wdata[GC_CPU_BIT])
  ) else $error("pin enable not from control write");
  AST_ALIAS_DECODE: assert property ( // see R5
    (wr_gc ##1 (i_mem.addr <= DROM0_TOP))
      |-> o_download_rom_sel == ($past(i_reg.wdata[GC_BOOT_BIT]) || o_download_rom_claim)
  ) else $error("alias window does not follow control bit");
  AST_BOOT_TIMEOUT: assert property ( // see R6
    ((st_q.boot_st == BOOT_TIMING) && (st_q.boot_cnt == BOOT_LAST) && !i_mem.responded)
      |=> st_q.boot0 && o_download_rom_claim ##1 !o_download_rom_claim
  ) else $error("timeout did not set alias");
  AST_VEC_CODE: assert property ( // see R8
    ((st_q.ack_st == ACK_IDLE) && i_iack.req && st_q.master_irq_enable && win_any && st_q.vb_written
      && !(win_serial && !win_serial_autovector_enable))
      |=> o_iack.done && (o_iack.vector == {$past(st_q.vb_nib), $past(win_code)})
  ) else $error("wrong generated vector");
  AST_DEFAULT_VEC: assert property ( // see R9
    (o_iack.done && !st_q.vb_written && ($past(st_q.ack_st) == ACK_IDLE))
      |-> o_iack.vector == VEC_RESET
  ) else $error("default vector not used");
  AST_VB_READ: assert property ( // see R10
    (i_reg.rd && (i_reg.addr == VEC_BASE_ADDR) && !st_q.vb_written)
      |=> (o_reg_rdata == VEC_RESET) ##1 (o_reg_rdata == BYTE_ZERO || $past(i_reg.rd))
  ) else $error("base readback wrong before first write");
  AST_PRIO_HIGH: assert property ( // see R13
    (win_any && (st_q.ack_st == ACK_IDLE)) |-> !(|(elig >> (win_code + 4'h1)))
  ) else $error("lower source won");
  AST_SER_FETCH: assert property ( // see R14
    ((st_q.ack_st == ACK_FETCH) && i_ser_vec.valid)
      |=> o_iack.done && !o_ser_vec_fetch && (o_iack.vector == $past(i_ser_vec.vector))
  ) else $error("serial vector not passed");
  AST_LOW_BITS_ZERO: assert property ( // see R16
    (wr_vb ##1 (i_reg.rd && (i_reg.addr == VEC_BASE_ADDR)))
      |=> o_reg_rdata[VB_LO-1:0] == NIB_ZERO
  ) else $error("low base bits not zero");
endmodule
`default_nettype wire

/* File: sim/gciv_ser_model.sv */
// Purpose: Serial controller model that answers vector fetches of the block
// Assumes: Fetch request is a level held until the vector is taken
// Notes: Vector bus shows a changing pattern whenever it is not valid outside reset, and holds 5A during reset
`timescale 1ns/1ns
`default_nettype none
module gciv_ser_model
  import gciv_pkg::*;
#(
  parameter logic [7:0] LOCAL_VEC = 8'h5f
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_fetch,
  input wire logic [3:0] i_delay,
  output gciv_pkg::gciv_servec_s o_ser_vec
);
  logic [3:0] cnt_q;
  logic sent_q;
  // ==========================================================
  // Answer once per fetch after i_delay cycles; slow answers test the wait
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_ser_vec.valid <= 1'b0;
      o_ser_vec.vector <= 8'h5a;
      cnt_q <= 4'h0;
      sent_q <= 1'b0;
    end else if (i_fetch && !sent_q && (cnt_q == i_delay)) begin
      o_ser_vec.valid <= 1'b1;
      o_ser_vec.vector <= LOCAL_VEC; // Receive vector of base 5C
      sent_q <= 1'b1;
    end else begin
      o_ser_vec.valid <= 1'b0;
      o_ser_vec.vector <= ~o_ser_vec.vector; // Stale data changes every cycle
      cnt_q <= (i_fetch && !sent_q) ? cnt_q + 4'h1 : (i_fetch ? cnt_q : 4'h0);
      sent_q <= i_fetch && sent_q;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_gciv_top.sv */
// Purpose: Self-checking bench of the general control and irq vector block
// Assumes: Boot timeout shortened to 4 cycles
// Notes: Level pins resolve from the block's output enable
`timescale 1ns/1ns
`default_nettype none
module tb_gciv_top;
  import gciv_pkg::*;
  localparam int TMO = 4;
  localparam logic [31:0] GC = GEN_CTRL_ADDR;
  localparam logic [31:0] VB = VEC_BASE_ADDR;
  logic clk, rst, pass_n, fetch, oe, chip_irq, rom_sel, claim, fast, irq;
  logic [7:0] rdata;
  logic [NUM_SRC-1:0] req;
  logic [2:0] serial_autovector_enable, pins_n, out_n, ext_n;
  logic [3:0] delay;
  gciv_lvls_t lvls;
  gciv_regreq_s rq;
  gciv_iack_s iq;
  gciv_iack_ans_s ans;
  gciv_servec_s sv;
  gciv_mem_s mq;
  int errors = 0;
  int checks = 0;
  int k;
  // Pin wire: block drives when enabled, else the outside level
  assign pins_n = oe ? out_n : ext_n;
  gciv_top #(.BOOT_TIMEOUT(TMO)) i_gciv_top (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_reg(rq), .o_reg_rdata(rdata),
    .i_src_req(req), .i_src_level(lvls), .i_serial_autovector_enable(serial_autovector_enable),
    .i_iack(iq), .o_iack(ans), .o_ack_passthrough_out_n(pass_n),
    .o_ser_vec_fetch(fetch), .i_ser_vec(sv), .i_encoded_irq_level_pins_in_n(pins_n),
    .o_encoded_irq_level_pins_out_n(out_n), .o_encoded_irq_level_pins_oe(oe),
    .o_chip_irq(chip_irq), .i_mem(mq), .o_download_rom_sel(rom_sel),
    .o_download_rom_claim(claim), .o_battery_ram_fast_timing(fast), .o_irq(irq)
  );
  gciv_ser_model i_gciv_ser_model (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_fetch(fetch), .i_delay(delay), .o_ser_vec(sv)
  );
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    rq.addr <= a;
    rq.wdata <= d;
    rq.wr <= 1'b1;
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    @(posedge clk);
    rq.addr <= a;
    rq.rd <= 1'b1;
    @(posedge clk);
    rq.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic ack(input logic [2:0] lvl);
    @(posedge clk);
    iq.req <= 1'b1;
    iq.level <= lvl;
    @(posedge clk);
    iq.req <= 1'b0;
    #1;
  endtask
  task automatic ack_vec(input logic [7:0] exp);
    ack(3'h5);
    check({7'h0, ans.done}, 8'h01);
    check(ans.vector, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tend(input string name);
    $display("test %s finished, checks=%0d errors=%0d", name, checks, errors);
  endtask
  task automatic conclude;
    $display("total checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock and watchdog; the whole run needs about 130 cycles
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    conclude();
  end
  // ==========================================================
  // Test sequence
  initial begin
    rst = 1'b1;
    rq = '0;
    iq = '0;
    mq = '0;
    req = '0;
    serial_autovector_enable = 3'h7;
    delay = 4'h0;
    ext_n = 3'h5;
    for (int i = 0; i < NUM_SRC; i++) begin
      lvls[i] = 3'h5;
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(GC, 8'h00);
    rd(VB, VEC_RESET);
    rd(32'hfff42004, 8'h00);
    rd(PIN_STAT_ADDR, 8'h02);
    tend("reset");
    // First access unanswered: alias claimed after the timeout
    @(posedge clk);
    mq.start <= 1'b1;
    @(posedge clk);
    mq.start <= 1'b0;
    for (k = 0; k < 20 && claim !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check(k[7:0], TMO[7:0]);
    rd(GC, 8'h80);
    mq.addr <= DROM0_TOP;
    idle(1);
    check({7'h0, rom_sel}, 8'h01);
    mq.addr <= 32'h00020000;
    idle(1);
    check({7'h0, rom_sel}, 8'h00);
    mq.addr <= 32'h0;
    wr(GC, 8'h00);
    idle(1);
    check({7'h0, rom_sel}, 8'h00);
    tend("boot");
    // Master enable low: pass every acknowledge, keep outputs quiet
    req <= 14'h0200;
    ack(3'h5);
    check({6'h0, ans.done, pass_n}, 8'h00);
    idle(2);
    check({3'h0, oe, chip_irq, out_n}, 8'h07);
    rd(EVT_STAT_ADDR, 8'h03);
    tend("gated");
    wr(GC, 8'h7f);
    rd(GC, 8'h07);
    check({3'h0, oe, chip_irq, out_n}, 8'h1a);
    check({7'h0, fast}, 8'h01);
    ack_vec(VEC_RESET);
    // Base write then read with no gap between the strobes
    @(posedge clk);
    rq.addr <= VB;
    rq.wdata <= 8'h5a;
    rq.wr <= 1'b1;
    @(posedge clk);
    rq.wr <= 1'b0;
    rq.rd <= 1'b1;
    @(posedge clk);
    rq.rd <= 1'b0;
    #1;
    check(rdata, 8'h50);
    ack_vec(8'h59);
    // Every source code alone, serial ones in auto-vector mode
    for (int c = 0; c < NUM_SRC; c++) begin
      req <= 14'h1 << c;
      ack_vec(8'h50 | 8'(c));
    end
    req <= 14'h2208;
    ack_vec(8'h5d);
    req <= 14'h0208;
    ack_vec(8'h59);
    tend("vectors");
    // Serial source without auto-vector: prompt then slow answer
    serial_autovector_enable <= 3'h5;
    req <= 14'h1000;
    for (int d = 0; d < 2; d++) begin
      delay <= 4'(d * 5);
      ack(3'h5);
      check({7'h0, fetch}, 8'h01);
      for (k = 0; k < 20 && ans.done !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      check({7'h0, ans.done}, 8'h01);
      check(ans.vector, 8'h5f);
    end
    tend("fetch");
    // Sticky events, mask and clear
    wr(EVT_MASK_ADDR, 8'h01);
    idle(3);
    check({7'h0, irq}, 8'h01);
    wr(EVT_STAT_ADDR, 8'h01);
    idle(3);
    check({7'h0, irq}, 8'h00);
    rd(EVT_STAT_ADDR, 8'h06);
    wr(EVT_MASK_ADDR, 8'h02);
    idle(3);
    check({7'h0, irq}, 8'h01);
    wr(GC, 8'h04);
    idle(3);
    check({3'h0, oe, chip_irq, out_n}, 8'h17);
    check({7'h0, irq}, 8'h00);
    tend("interrupt");
    // Reset in mid-run: enable and alias must clear again
    wr(GC, 8'h82);
    @(posedge clk);
    rst <= 1'b1;
    idle(3);
    rst <= 1'b0;
    check({7'h0, pass_n}, 8'h01);
    rd(GC, 8'h00);
    rd(VB, VEC_RESET);
    tend("reset again");
    conclude();
  end
endmodule
`default_nettype wire
